// ---- design/pto_pkg.sv ----
// shared constants and types of the pressure and temperature output registers
package pto_pkg;

    // apb geometry
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;

    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_STATUS = 8'h27;
    localparam logic [7:0] IDX_PRESS_LO = 8'h28;
    localparam logic [7:0] IDX_PRESS_MID = 8'h29;
    localparam logic [7:0] IDX_PRESS_HI = 8'h2A;
    localparam logic [7:0] IDX_TEMP_LO = 8'h2B;
    localparam logic [7:0] IDX_TEMP_HI = 8'h2C;
    localparam logic [7:0] IDX_REF_PRESS = 8'h30;
    localparam logic [7:0] IDX_CTRL = 8'h31;

    // byte addresses on the apb
    localparam logic [APB_AW-1:0] ADDR_STATUS = APB_AW'({IDX_STATUS, 2'b00});
    localparam logic [APB_AW-1:0] ADDR_PRESS_LO = APB_AW'({IDX_PRESS_LO, 2'b00});
    localparam logic [APB_AW-1:0] ADDR_PRESS_MID = APB_AW'({IDX_PRESS_MID, 2'b00});
    localparam logic [APB_AW-1:0] ADDR_PRESS_HI = APB_AW'({IDX_PRESS_HI, 2'b00});
    localparam logic [APB_AW-1:0] ADDR_TEMP_LO = APB_AW'({IDX_TEMP_LO, 2'b00});
    localparam logic [APB_AW-1:0] ADDR_TEMP_HI = APB_AW'({IDX_TEMP_HI, 2'b00});
    localparam logic [APB_AW-1:0] ADDR_REF_PRESS = APB_AW'({IDX_REF_PRESS, 2'b00});
    localparam logic [APB_AW-1:0] ADDR_CTRL = APB_AW'({IDX_CTRL, 2'b00});

    // status field positions
    localparam int STAT_PDA = 0;
    localparam int STAT_TDA = 1;
    localparam int STAT_POR = 4;
    localparam int STAT_TOR = 5;

    // control field positions
    localparam int CTRL_ZEROING = 0;

    // result widths
    localparam int PRESS_W = 24;
    localparam int TEMP_W = 16;

    // reset values
    localparam logic [PRESS_W-1:0] RST_PRESS = 24'h000000;
    localparam logic [TEMP_W-1:0] RST_TEMP = 16'h0000;
    localparam logic [PRESS_W-1:0] RST_REF = 24'h000000;
    localparam logic RST_CTRL_ZEROING = 1'b0;

    // default clip limits of the pressure result
    localparam logic [PRESS_W-1:0] DEF_PRESS_MAX = 24'h7FFFFF;
    localparam logic [PRESS_W-1:0] DEF_PRESS_MIN = 24'h800000;

    // sticky flags of the output data
    typedef struct packed {
        logic tor;
        logic por;
        logic tda;
        logic pda;
    } pto_flags_t;

    localparam pto_flags_t RST_FLAGS = '{tor: 1'b0, por: 1'b0, tda: 1'b0, pda: 1'b0};

endpackage : pto_pkg

// ---- design/pto_output_regs.sv ----
// Contract
// - pressure bits 7:0 read at 28h
// - pressure bits 15:8 read at 29h
// - pressure bits 23:16 read at 2Ah
// - pressure result is measured minus reference
// - pressure result is 24-bit two's complement
// - out-of-range pressure saturates, never wraps
// - temperature bits 7:0 read at 2Bh
// - temperature bits 15:8 read at 2Ch
// - temperature result is 16-bit two's complement
// - pressure flag set per sample, read 2Ah clears
// - temperature flag set per sample, read 2Ch clears
// - overrun when sample arrives with flag set and no clearing read that cycle
`timescale 1ns/1ns
`default_nettype none

module pto_output_regs
    import pto_pkg::*;
#(
    parameter logic [PRESS_W-1:0] PRESS_MAX = DEF_PRESS_MAX,
    parameter logic [PRESS_W-1:0] PRESS_MIN = DEF_PRESS_MIN
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    output logic [APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic press_sample_valid,
    input wire logic [PRESS_W-1:0] press_sample,
    input wire logic temp_sample_valid,
    input wire logic [TEMP_W-1:0] temp_sample
);

    logic [PRESS_W-1:0] press_q;
    logic [TEMP_W-1:0] temp_q;
    logic [PRESS_W-1:0] ref_q;
    logic zeroing_q;
    pto_flags_t flags;
    logic capture;
    logic rd_cap;
    logic wr_cap;
    logic clr_press;
    logic clr_temp;
    logic signed [PRESS_W:0] diff;
    logic signed [PRESS_W:0] lim_max;
    logic signed [PRESS_W:0] lim_min;
    logic [PRESS_W-1:0] next_press;
    logic [APB_DW-1:0] next_prdata;
    logic next_slverr;

    // one wait state: the access phase is sampled once, answered next cycle
    assign capture = psel & penable & ~pready;
    assign rd_cap = capture & ~pwrite;
    assign wr_cap = capture & pwrite;

    // reading the high bytes clears the matching flags
    assign clr_press = rd_cap & (paddr == ADDR_PRESS_HI);
    assign clr_temp = rd_cap & (paddr == ADDR_TEMP_HI);

    // difference to the reference, one bit wider so it cannot wrap
    always_comb
    begin
        lim_max = $signed({PRESS_MAX[PRESS_W-1], PRESS_MAX});
        lim_min = $signed({PRESS_MIN[PRESS_W-1], PRESS_MIN});
        if (zeroing_q)
        begin
            diff = $signed({press_sample[PRESS_W-1], press_sample})
                - $signed({ref_q[PRESS_W-1], ref_q});
        end
        else
        begin
            diff = $signed({press_sample[PRESS_W-1], press_sample});
        end
        if (diff > lim_max)
        begin
            next_press = PRESS_MAX;
        end
        else if (diff < lim_min)
        begin
            next_press = PRESS_MIN;
        end
        else
        begin
            next_press = diff[PRESS_W-1:0];
        end
    end

    // pressure result, loaded once per output data cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            press_q <= RST_PRESS;
        end
        else if (press_sample_valid)
        begin
            press_q <= next_press;
        end
    end

    // temperature result, stored as delivered in two's complement
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            temp_q <= RST_TEMP;
        end
        else if (temp_sample_valid)
        begin
            temp_q <= temp_sample;
        end
    end

    // software reference and zeroing control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_q <= RST_REF;
            zeroing_q <= RST_CTRL_ZEROING;
        end
        else if (wr_cap)
        begin
            if (paddr == ADDR_REF_PRESS)
            begin
                ref_q <= pwdata[PRESS_W-1:0];
            end
            if (paddr == ADDR_CTRL)
            begin
                zeroing_q <= pwdata[CTRL_ZEROING];
            end
        end
    end

    // sticky flags; a new sample wins over a clearing read for pda and tda, the clearing read wins for por and tor
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags <= RST_FLAGS;
        end
        else
        begin
            flags.pda <= press_sample_valid | (flags.pda & ~clr_press);
            flags.por <= (press_sample_valid & flags.pda & ~clr_press)
                | (flags.por & ~clr_press);
            flags.tda <= temp_sample_valid | (flags.tda & ~clr_temp);
            flags.tor <= (temp_sample_valid & flags.tda & ~clr_temp)
                | (flags.tor & ~clr_temp);
        end
    end

    // read mux and decode; writes to result bytes are dropped silently
    always_comb
    begin
        next_prdata = '0;
        next_slverr = 1'b0;
        case (paddr)
            ADDR_PRESS_LO:
            begin
                next_prdata = {24'h000000, press_q[7:0]};
            end
            ADDR_PRESS_MID:
            begin
                next_prdata = {24'h000000, press_q[15:8]};
            end
            ADDR_PRESS_HI:
            begin
                next_prdata = {24'h000000, press_q[23:16]};
            end
            ADDR_TEMP_LO:
            begin
                next_prdata = {24'h000000, temp_q[7:0]};
            end
            ADDR_TEMP_HI:
            begin
                next_prdata = {24'h000000, temp_q[15:8]};
            end
            ADDR_STATUS:
            begin
                next_prdata[STAT_PDA] = flags.pda;
                next_prdata[STAT_TDA] = flags.tda;
                next_prdata[STAT_POR] = flags.por;
                next_prdata[STAT_TOR] = flags.tor;
            end
            ADDR_REF_PRESS:
            begin
                next_prdata = {8'h00, ref_q};
            end
            ADDR_CTRL:
            begin
                next_prdata[CTRL_ZEROING] = zeroing_q;
            end
            default:
            begin
                next_slverr = 1'b1; // unmapped address
            end
        endcase
    end

    // apb answer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= capture;
            pslverr <= capture & next_slverr;
            if (rd_cap)
            begin
                prdata <= next_prdata;
            end
        end
    end

    // checks on the design's own behaviour

    sequence s_rd_at(logic [APB_AW-1:0] a);
        rd_cap && (paddr == a);
    endsequence

    property p_press_lo;
        @(posedge pclk) disable iff (!presetn)
        s_rd_at(ADDR_PRESS_LO) |=> (prdata == {24'h000000, $past(press_q[7:0])});
    endproperty
    a_press_lo: assert property (p_press_lo) else $error("pressure low byte wrong");

    property p_press_mid;
        @(posedge pclk) disable iff (!presetn)
        s_rd_at(ADDR_PRESS_MID) |=> (prdata[7:0] == $past(press_q[15:8]))
            && (prdata[31:8] == 24'h000000);
    endproperty
    a_press_mid: assert property (p_press_mid) else $error("pressure mid byte wrong");

    property p_press_hi;
        @(posedge pclk) disable iff (!presetn)
        s_rd_at(ADDR_PRESS_HI) |=> pready && !pslverr
            && (prdata[7:0] == $past(press_q[23:16]));
    endproperty
    a_press_hi: assert property (p_press_hi) else $error("pressure high byte wrong");

    property p_subtract;
        @(posedge pclk) disable iff (!presetn)
        press_sample_valid && zeroing_q && (diff <= lim_max) && (diff >= lim_min)
            |=> (press_q == $past(press_sample) - $past(ref_q));
    endproperty
    a_subtract: assert property (p_subtract) else $error("pressure not reference relative");

    property p_sign;
        @(posedge pclk) disable iff (!presetn)
        press_sample_valid |=> (press_q[PRESS_W-1] == $past(diff[PRESS_W]));
    endproperty
    a_sign: assert property (p_sign) else $error("pressure sign bit wrong");

    property p_saturate;
        @(posedge pclk) disable iff (!presetn)
        press_sample_valid && (diff > lim_max) |=> (press_q == PRESS_MAX);
    endproperty
    a_saturate: assert property (p_saturate) else $error("pressure not clipped high");

    property p_temp_bytes;
        @(posedge pclk) disable iff (!presetn)
        s_rd_at(ADDR_TEMP_LO) or s_rd_at(ADDR_TEMP_HI)
            |=> (prdata[7:0] == ($past(paddr) == ADDR_TEMP_LO
                ? $past(temp_q[7:0]) : $past(temp_q[15:8])));
    endproperty
    a_temp_bytes: assert property (p_temp_bytes) else $error("temperature byte wrong");

    property p_temp_load;
        @(posedge pclk) disable iff (!presetn)
        temp_sample_valid |=> (temp_q == $past(temp_sample)) && flags.tda;
    endproperty
    a_temp_load: assert property (p_temp_load) else $error("temperature not loaded");

    property p_pda_clear;
        @(posedge pclk) disable iff (!presetn)
        s_rd_at(ADDR_PRESS_HI) ##0 !press_sample_valid |=> !flags.pda && !flags.por;
    endproperty
    a_pda_clear: assert property (p_pda_clear) else $error("pressure flags not cleared");

    property p_tda_clear;
        @(posedge pclk) disable iff (!presetn)
        s_rd_at(ADDR_TEMP_HI) ##0 !temp_sample_valid
            |=> (!flags.tda && !flags.tor) ##1 (!flags.tda || $past(temp_sample_valid));
    endproperty
    a_tda_clear: assert property (p_tda_clear) else $error("temperature flag not cleared");

    property p_overrun;
        @(posedge pclk) disable iff (!presetn)
        press_sample_valid && flags.pda && !clr_press |=> flags.por && flags.pda;
    endproperty
    a_overrun: assert property (p_overrun) else $error("pressure overrun missed");

    property p_ro_write;
        @(posedge pclk) disable iff (!presetn)
        wr_cap && (paddr == ADDR_PRESS_HI) && !press_sample_valid
            |=> $stable(press_q) && !pslverr;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("write changed pressure result");

    property p_answer;
        @(posedge pclk) disable iff (!presetn)
        capture |=> pready ##1 !pready;
    endproperty
    a_answer: assert property (p_answer) else $error("apb answer not one cycle");

    property p_clip_low;
        @(posedge pclk) disable iff (!presetn)
        press_sample_valid && (diff < lim_min) |=> (press_q == PRESS_MIN);
    endproperty
    a_clip_low: assert property (p_clip_low) else $error("pressure not clipped low");

    property p_ro_temp;
        @(posedge pclk) disable iff (!presetn)
        wr_cap && (paddr == ADDR_TEMP_HI) && !temp_sample_valid
            |=> $stable(temp_q) && !pslverr;
    endproperty
    a_ro_temp: assert property (p_ro_temp) else $error("write changed temperature result");

    property p_status;
        @(posedge pclk) disable iff (!presetn)
        s_rd_at(ADDR_STATUS) |=> (prdata == {26'h0000000, $past(flags.tor), $past(flags.por),
            2'b00, $past(flags.tda), $past(flags.pda)});
    endproperty
    a_status: assert property (p_status) else $error("status flags read wrong");

    property p_temp_overrun;
        @(posedge pclk) disable iff (!presetn)
        temp_sample_valid && flags.tda && !clr_temp |=> flags.tor && flags.tda;
    endproperty
    a_temp_overrun: assert property (p_temp_overrun) else $error("temperature overrun missed");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        capture && next_slverr |=> pready && pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped address not refused");

endmodule : pto_output_regs

`default_nettype wire

// ---- dv/pto_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// apb master standing in for the host processor
module pto_host_model
    import pto_pkg::*;
(
    input wire logic pclk,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [APB_AW-1:0] paddr,
    output logic [APB_DW-1:0] pwdata
);
    // idle bus at time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // setup, then access held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // stale data must not look valid
    endtask : xfer
endmodule : pto_host_model
`default_nettype wire

// ---- dv/pto_output_regs_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module pto_output_regs_bench
    import pto_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata, prdata;
    logic pv = 1'b0;
    logic tv = 1'b0;
    logic [PRESS_W-1:0] ps = '0;
    logic [TEMP_W-1:0] ts = '0;
    logic [PRESS_W-1:0] rp, rr;
    logic [TEMP_W-1:0] rt;
    logic [33:0] notes[$];
    logic [33:0] n;
    int mismatches = 0;
    int check_count = 0;
    logic [PRESS_W-1:0] tm[4] = '{24'h000200, 24'h7FFFF0, 24'h800010, 24'hFFFFFF};
    logic [PRESS_W-1:0] tr[4] = '{24'h000100, 24'hFFFF00, 24'h000100, 24'h7FFFFF};

    // 100 MHz clock
    always #5 pclk = ~pclk;

    pto_output_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .press_sample_valid(pv), .press_sample(ps),
        .temp_sample_valid(tv), .temp_sample(ts));

    pto_host_model i_host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // note: {check data, expected error, expected data}
    task automatic rd(input logic [APB_AW-1:0] a, input logic [31:0] e, input logic err);
        notes.push_back({~err, err, e});
        i_host.xfer(1'b0, a, 32'h0);
    endtask : rd

    task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d, input logic err);
        notes.push_back({1'b0, err, 32'h0});
        i_host.xfer(1'b1, a, d);
    endtask : wr

    task automatic rdp(input logic [PRESS_W-1:0] v);
        rd(ADDR_PRESS_LO, {24'h0, v[7:0]}, 1'b0);
        rd(ADDR_PRESS_MID, {24'h0, v[15:8]}, 1'b0);
        rd(ADDR_PRESS_HI, {24'h0, v[23:16]}, 1'b0);
    endtask : rdp

    task automatic rdt(input logic [TEMP_W-1:0] v);
        rd(ADDR_TEMP_LO, {24'h0, v[7:0]}, 1'b0);
        rd(ADDR_TEMP_HI, {24'h0, v[15:8]}, 1'b0);
    endtask : rdt

    // one-cycle sample strobes carrying rp and rt
    task automatic smp(input logic p, input logic t);
        @(posedge pclk);
        pv <= p;
        tv <= t;
        ps <= rp;
        ts <= rt;
        @(posedge pclk);
        pv <= 1'b0;
        tv <= 1'b0;
    endtask : smp

    // measured minus reference, clipped to the signed range
    function automatic logic [PRESS_W-1:0] sat(input logic [PRESS_W-1:0] m,
        input logic [PRESS_W-1:0] r);
        logic signed [PRESS_W:0] d;
        d = $signed({m[PRESS_W-1], m}) - $signed({r[PRESS_W-1], r});
        if (d > 25'sh07FFFFF)
            return 24'h7FFFFF;
        if (d < -25'sh0800000)
            return 24'h800000;
        return d[PRESS_W-1:0];
    endfunction : sat

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    // monitor: each completed transfer takes the oldest note
    always @(posedge pclk)
    begin
        if (pready === 1'b1 && notes.size() > 0)
        begin
            n = notes.pop_front();
            chk({31'h0, pslverr}, {31'h0, n[32]});
            if (n[33])
                chk(prdata, n[31:0]);
        end
    end

    // watchdog against a hung handshake
    initial
    begin
        #50000;
        mismatches++;
        stop_test();
    end

    initial
    begin
        void'($urandom(32'hE183));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_STATUS, 32'h0, 1'b0);
        rdp(24'h0);
        rdt(16'h0);
        $display("test reset done");
        // random samples, every other one doubled for overrun
        for (int i = 0; i < 4; i++)
        begin
            rp = PRESS_W'($urandom);
            rt = TEMP_W'($urandom);
            if (i[0])
                smp(1'b1, 1'b1);
            smp(1'b1, 1'b1);
            rd(ADDR_STATUS, i[0] ? 32'h33 : 32'h03, 1'b0);
            rdp(rp);
            rd(ADDR_STATUS, i[0] ? 32'h22 : 32'h02, 1'b0);
            rdt(rt);
            rd(ADDR_STATUS, 32'h0, 1'b0);
        end
        $display("test samples done");
        // writes to results ignored, unmapped refused
        wr(ADDR_PRESS_LO, 32'hFFFFFFFF, 1'b0);
        wr(ADDR_TEMP_HI, 32'hFFFFFFFF, 1'b0);
        wr(ADDR_PRESS_HI, 32'hFFFFFFFF, 1'b0);
        rdp(rp);
        rdt(rt);
        rd(12'hFFC, 32'h0, 1'b1);
        wr(12'hFFC, 32'h5, 1'b1);
        $display("test read only done");
        // automatic zeroing with clipping at both ends
        wr(ADDR_CTRL, 32'h1, 1'b0);
        rd(ADDR_CTRL, 32'h1, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            rp = tm[i];
            rr = tr[i];
            wr(ADDR_REF_PRESS, {8'h0, rr}, 1'b0);
            rd(ADDR_REF_PRESS, {8'h0, rr}, 1'b0);
            smp(1'b1, 1'b0);
            rdp(sat(rp, rr));
        end
        $display("test zeroing done");
        repeat (3) @(posedge pclk);
        stop_test();
    end
endmodule : pto_output_regs_bench
`default_nettype wire
